// ---- pkg/uart_ctrl_pkg.sv ----
// shared constants for the serial port low control byte
package uart_ctrl_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] CTRL_LOW_ADDR = 8'h05;
  localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int PAR_GEN_BIT = 7;
  localparam int TX_ODD_BIT = 6;
  localparam int RX_ODD_BIT = 5;
  localparam int PAR_ERR_BIT = 4;
  localparam int CLK_SEL_HI = 3;
  localparam int CLK_SEL_LO = 2;
  localparam int TX_IE_BIT = 1;
  localparam int TX_PEND_BIT = 0;
  // -----------------------------------------------------------------
  // modes and counts
  // -----------------------------------------------------------------
  localparam logic [1:0] MODE_NINE_FIXED = 2'h2;
  localparam logic [1:0] MODE_NINE_BAUD = 2'h3;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [2:0] PRE_LAST_DIV8 = 3'h7;
  localparam logic [2:0] PRE_LAST_DIV4 = 3'h3;
  localparam logic [2:0] PRE_LAST_DIV2 = 3'h1;
  localparam logic [2:0] PRE_LAST_DIV1 = 3'h0;
  localparam logic [2:0] PRE_RESET = 3'h0;
  localparam logic [3:0] OS_RESET = 4'h0;
  localparam logic [7:0] BAUD_RESET = 8'h00;
endpackage : uart_ctrl_pkg

// ---- pkg/clk_sel_if.sv ----
// carries clock selection and tick strobes between control and divider
`timescale 1ns/1ps
`default_nettype none
interface clk_sel_if;
  logic [1:0] sel;
  logic [1:0] mode;
  logic [7:0] divisor;
  logic port_tick;
  logic bit_tick;
  modport gen (input sel, input mode, input divisor, output port_tick, output bit_tick);
  modport user (output sel, output mode, output divisor, input port_tick, input bit_tick);
endinterface : clk_sel_if
`default_nettype wire

// ---- core/serial_clock_gen.sv ----
// divides the system clock into port and bit-rate tick strobes
`timescale 1ns/1ps
`default_nettype none
module serial_clock_gen
  import uart_ctrl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  clk_sel_if.gen cs
);
  logic [2:0] pre;
  logic [3:0] os;
  logic [7:0] baud;
  logic os_step;

  function automatic logic [2:0] pre_last(input logic [1:0] sel);
    case (sel)
      2'h0: pre_last = PRE_LAST_DIV8;
      2'h1: pre_last = PRE_LAST_DIV4;
      2'h2: pre_last = PRE_LAST_DIV2;
      default: pre_last = PRE_LAST_DIV1;
    endcase
  endfunction : pre_last

  // -----------------------------------------------------------------
  // prescaler
  // -----------------------------------------------------------------
  // >= so a switch to a faster ratio never waits for a wrap
  assign cs.port_tick = (pre >= pre_last(cs.sel));
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || cs.port_tick) begin
      pre <= PRE_RESET;
    end else begin
      pre <= pre + 3'h1;
    end
  end

  // -----------------------------------------------------------------
  // bit rate: fixed /16 in mode 2, /16*(divisor+1) in mode 3
  // -----------------------------------------------------------------
  assign os_step = cs.port_tick && (cs.mode != MODE_NINE_BAUD || baud >= cs.divisor);
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || (cs.port_tick && os_step)) begin
      baud <= BAUD_RESET;
    end else if (cs.port_tick) begin
      baud <= baud + 8'h01;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      os <= OS_RESET;
    end else if (os_step) begin
      os <= os + 4'h1;
    end
  end
  assign cs.bit_tick = os_step && (os == OVERSAMPLE_LAST) && cs.mode[1];
endmodule : serial_clock_gen
`default_nettype wire

// ---- core/uart_parity_clock_control.sv ----
// low control byte of the second serial port: parity, clock select, tx interrupt
//
// Contract
// - bit 7 enables ninth-bit parity generation; bit 6 picks even or odd.
// - bit 5 picks even or odd check for received nine-bit frames.
// - bit 4 flags a received parity mismatch in nine-bit modes.
// - with generation off, receive parity select and error flag are ignored.
// - bit 1 gates the transmit interrupt request onto the processor line.
// - bit 0 reads pending; writing zero clears it, software must do so.
// - modes 2 and 3 move nine-bit frames at clock/16 or baud divisor.
// - with generation off the ninth transmit bit comes from its software field.
`timescale 1ns/1ps
`default_nettype none
module uart_parity_clock_control
  import uart_ctrl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [1:0] mode_i,
  input wire logic ninth_tx_bit_field_i,
  input wire logic [7:0] baud_divisor_value_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_done_i,
  input wire logic rx_frame_done_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ninth_i,
  output logic tx_ninth_bit_o,
  output logic tx_irq_o,
  output logic port_tick_o,
  output logic bit_tick_o
);
  logic par_gen;
  logic tx_odd;
  logic rx_odd;
  logic par_err;
  logic [1:0] clk_sel;
  logic tx_ie;
  logic tx_pend;
  logic wr_hit;
  logic nine_mode;
  logic rx_check;
  logic rx_bad;
  logic next_ninth;

  clk_sel_if cs ();

  // parity bit that makes the nine bits even (odd=0) or odd (odd=1)
  function automatic logic parity_of(input logic [7:0] data, input logic odd);
    parity_of = (^data) ^ odd;
  endfunction : parity_of

  // -----------------------------------------------------------------
  // register write
  // -----------------------------------------------------------------
  assign wr_hit = reg_wr_i && (reg_addr_i == CTRL_LOW_ADDR);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      par_gen <= CTRL_LOW_RESET[PAR_GEN_BIT];
      tx_odd <= CTRL_LOW_RESET[TX_ODD_BIT];
      rx_odd <= CTRL_LOW_RESET[RX_ODD_BIT];
      clk_sel <= CTRL_LOW_RESET[CLK_SEL_HI:CLK_SEL_LO];
      tx_ie <= CTRL_LOW_RESET[TX_IE_BIT];
    end else if (wr_hit) begin
      par_gen <= reg_wdata_i[PAR_GEN_BIT];
      tx_odd <= reg_wdata_i[TX_ODD_BIT];
      rx_odd <= reg_wdata_i[RX_ODD_BIT];
      clk_sel <= reg_wdata_i[CLK_SEL_HI:CLK_SEL_LO];
      tx_ie <= reg_wdata_i[TX_IE_BIT];
    end
  end

  // -----------------------------------------------------------------
  // receive parity check
  // -----------------------------------------------------------------
  assign nine_mode = mode_i[1];
  // only meaningful with generation on; otherwise the flag is left alone
  assign rx_check = rx_frame_done_i && nine_mode && par_gen;
  assign rx_bad = rx_ninth_i != parity_of(rx_data_i, rx_odd);

  // a frame result beats a software write in the same cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      par_err <= CTRL_LOW_RESET[PAR_ERR_BIT];
    end else if (rx_check) begin
      par_err <= rx_bad;
    end else if (wr_hit) begin
      par_err <= reg_wdata_i[PAR_ERR_BIT];
    end
  end

  // -----------------------------------------------------------------
  // transmit interrupt
  // -----------------------------------------------------------------
  // set wins over a clearing write so no completion is lost
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_pend <= CTRL_LOW_RESET[TX_PEND_BIT];
    end else if (tx_done_i) begin
      tx_pend <= 1'b1;
    end else if (wr_hit && !reg_wdata_i[TX_PEND_BIT]) begin
      tx_pend <= 1'b0;
    end
  end
  assign tx_irq_o = tx_pend && tx_ie;

  // -----------------------------------------------------------------
  // ninth transmit bit
  // -----------------------------------------------------------------
  assign next_ninth = par_gen ? parity_of(tx_data_i, tx_odd) : ninth_tx_bit_field_i;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_ninth_bit_o <= 1'b0;
    end else begin
      tx_ninth_bit_o <= next_ninth;
    end
  end

  // -----------------------------------------------------------------
  // register read, one cycle latency
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= CTRL_LOW_RESET;
    end else if (reg_rd_i && reg_addr_i == CTRL_LOW_ADDR) begin
      reg_rdata_o <= {par_gen, tx_odd, rx_odd, par_err, clk_sel, tx_ie, tx_pend};
    end else if (reg_rd_i) begin
      reg_rdata_o <= UNMAPPED_READ;
    end
  end

  // -----------------------------------------------------------------
  // clock divider
  // -----------------------------------------------------------------
  assign cs.sel = clk_sel;
  assign cs.mode = mode_i;
  assign cs.divisor = baud_divisor_value_i;
  assign port_tick_o = cs.port_tick;
  assign bit_tick_o = cs.bit_tick;

  serial_clock_gen u_clk_gen (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .cs(cs.gen)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  par_gen_bit_a: assert property (
    par_gen |=> tx_ninth_bit_o == ((^$past(tx_data_i)) ^ $past(tx_odd)))
    else $error("generated ninth bit has wrong parity");
  ninth_field_a: assert property (
    !par_gen |=> tx_ninth_bit_o == $past(ninth_tx_bit_field_i))
    else $error("ninth bit does not follow software field");
  perr_set_a: assert property (
    rx_frame_done_i && mode_i[1] && par_gen && (rx_ninth_i == ((^rx_data_i) ^ !rx_odd))
    |=> par_err)
    else $error("parity mismatch not flagged");
  perr_good_a: assert property (
    rx_frame_done_i && mode_i[1] && par_gen && (rx_ninth_i == ((^rx_data_i) ^ rx_odd))
    |=> !par_err)
    else $error("good frame flagged as parity error");
  perr_ignore_a: assert property (
    !par_gen && !wr_hit |=> $stable(par_err))
    else $error("parity flag moved with generation off");
  irq_gate_a: assert property (
    tx_done_i ##1 !wr_hit[*2] |-> (tx_irq_o == tx_ie))
    else $error("tx interrupt not gated by enable");
  pend_set_wins_a: assert property (
    tx_done_i && wr_hit && !reg_wdata_i[TX_PEND_BIT] |=> tx_pend)
    else $error("pending lost under a clearing write");
  pend_clear_a: assert property (
    wr_hit && !reg_wdata_i[TX_PEND_BIT] && !tx_done_i |=> !tx_pend && !tx_irq_o)
    else $error("writing zero did not clear pending");
  div8_rate_a: assert property (
    (port_tick_o && clk_sel == 2'h0 && !wr_hit) ##1 (!wr_hit && clk_sel == 2'h0)[*8]
    |-> $past(port_tick_o, 8) && !$past(port_tick_o, 1) && port_tick_o == 1'b1)
    else $error("divide by 8 tick spacing wrong");
  div1_rate_a: assert property (
    clk_sel == 2'h3 |-> port_tick_o)
    else $error("divide by 1 does not tick every cycle");
  fixed_bit_a: assert property (
    bit_tick_o |-> mode_i[1])
    else $error("bit tick outside nine-bit modes");

  odd_gen_c: cover property (par_gen && tx_odd && tx_done_i);
  perr_hit_c: cover property (rx_check && rx_bad);
  clear_race_c: cover property (tx_done_i && wr_hit && !reg_wdata_i[TX_PEND_BIT]);
  baud_tick_c: cover property (bit_tick_o && mode_i == MODE_NINE_BAUD);
endmodule : uart_parity_clock_control
`default_nettype wire

// ---- dv/line_partner.sv ----
// far-side transceiver model: delivers received frames, reports finished sends
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  input wire logic clk_i,
  output logic [7:0] rx_data_o,
  output logic rx_ninth_o,
  output logic rx_done_o,
  output logic tx_done_o
);
  initial begin
    rx_data_o = 8'h00;
    rx_ninth_o = 1'b0;
    rx_done_o = 1'b0;
    tx_done_o = 1'b0;
  end
  // ninth bit carries the chosen parity sense; bad flips it on purpose
  task automatic send(input logic [7:0] d, input logic odd, input logic bad);
    @(negedge clk_i);
    rx_data_o = d;
    rx_ninth_o = (^d) ^ odd ^ bad;
    rx_done_o = 1'b1;
    @(negedge clk_i);
    rx_done_o = 1'b0;
    // outside a frame the lines must not keep the last value
    rx_data_o = ~d;
    rx_ninth_o = ~rx_ninth_o;
  endtask : send
  task automatic finish_tx();
    @(negedge clk_i);
    tx_done_o = 1'b1;
    @(negedge clk_i);
    tx_done_o = 1'b0;
  endtask : finish_tx
endmodule : line_partner
`default_nettype wire

// ---- dv/uart_parity_clock_control_test.sv ----
// self-checking bench for the serial port low control byte
`timescale 1ns/1ps
`default_nettype none
`define check(what, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value %s exp %h got %h", what, exp, got); \
  end \
end
module uart_parity_clock_control_test;
  import uart_ctrl_pkg::*;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, rx_data_i;
  logic [1:0] mode_i = 2'h0;
  logic ninth_tx_bit_field_i = 1'b0, tx_done_i, rx_frame_done_i, rx_ninth_i;
  logic [7:0] baud_divisor_value_i = 8'h00, tx_data_i = 8'h07;
  logic tx_ninth_bit_o, tx_irq_o, port_tick_o, bit_tick_o;
  int num_errors = 0;
  int tests_run = 0;
  always #12.5 mclk_i = ~mclk_i;
  uart_parity_clock_control dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .mode_i(mode_i),
    .ninth_tx_bit_field_i(ninth_tx_bit_field_i), .baud_divisor_value_i(baud_divisor_value_i),
    .tx_data_i(tx_data_i), .tx_done_i(tx_done_i), .rx_frame_done_i(rx_frame_done_i),
    .rx_data_i(rx_data_i), .rx_ninth_i(rx_ninth_i), .tx_ninth_bit_o(tx_ninth_bit_o),
    .tx_irq_o(tx_irq_o), .port_tick_o(port_tick_o), .bit_tick_o(bit_tick_o));
  line_partner far (.clk_i(mclk_i), .rx_data_o(rx_data_i), .rx_ninth_o(rx_ninth_i),
    .rx_done_o(rx_frame_done_i), .tx_done_o(tx_done_i));
  // -----------------------------------------------------------------
  // register bus
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask : rd
  // counts strobes on settled outputs, one look per cycle
  task automatic ticks(input int n, output int pt, output int bt);
    pt = 0;
    bt = 0;
    repeat (n) begin
      @(negedge mclk_i);
      if (port_tick_o === 1'b1) pt++;
      if (bit_tick_o === 1'b1) bt++;
    end
  endtask : ticks
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic s_map();
    logic [7:0] v;
    rd(CTRL_LOW_ADDR, v);
    `check("reset byte", 8'h00, v)
    wr(8'h06, 8'hff);
    rd(CTRL_LOW_ADDR, v);
    `check("after stray write", 8'h00, v)
    rd(8'h06, v);
    `check("unmapped read", 8'h00, v)
    wr(CTRL_LOW_ADDR, 8'hee);
    rd(CTRL_LOW_ADDR, v);
    `check("byte readback", 8'hee, v)
  endtask : s_map
  task automatic s_ninth();
    logic [7:0] cfg [4] = '{8'h80, 8'hc0, 8'h00, 8'h40};
    logic fld [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0] dat [4] = '{8'h07, 8'h06, 8'h07, 8'h07};
    logic exp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_LOW_ADDR, cfg[i]);
      ninth_tx_bit_field_i = fld[i];
      tx_data_i = dat[i];
      repeat (2) @(negedge mclk_i);
      `check("ninth bit", exp[i], tx_ninth_bit_o)
    end
  endtask : s_ninth
  task automatic s_rx();
    logic [7:0] v;
    mode_i = MODE_NINE_FIXED;
    wr(CTRL_LOW_ADDR, 8'h80);
    far.send(8'h03, 1'b0, 1'b1);
    rd(CTRL_LOW_ADDR, v);
    `check("even bad frame", 8'h90, v)
    far.send(8'h03, 1'b0, 1'b0);
    rd(CTRL_LOW_ADDR, v);
    `check("even good frame", 8'h80, v)
    wr(CTRL_LOW_ADDR, 8'ha0);
    far.send(8'h03, 1'b0, 1'b0);
    rd(CTRL_LOW_ADDR, v);
    `check("odd check", 8'hb0, v)
    wr(CTRL_LOW_ADDR, 8'h20);
    far.send(8'h03, 1'b0, 1'b0);
    rd(CTRL_LOW_ADDR, v);
    `check("check off", 8'h20, v)
    mode_i = 2'h1;
    wr(CTRL_LOW_ADDR, 8'h80);
    far.send(8'h03, 1'b0, 1'b1);
    rd(CTRL_LOW_ADDR, v);
    `check("eight-bit mode", 8'h80, v)
  endtask : s_rx
  task automatic s_irq();
    logic [7:0] v;
    wr(CTRL_LOW_ADDR, 8'h02);
    far.finish_tx();
    `check("irq raised", 1'b1, tx_irq_o)
    wr(CTRL_LOW_ADDR, 8'h00);
    `check("irq cleared", 1'b0, tx_irq_o)
    far.finish_tx();
    `check("irq masked", 1'b0, tx_irq_o)
    rd(CTRL_LOW_ADDR, v);
    `check("pending bit", 8'h01, v)
    wr(CTRL_LOW_ADDR, 8'h03);
    `check("write one keeps", 1'b1, tx_irq_o)
    wr(CTRL_LOW_ADDR, 8'h02);
    `check("cleared by zero", 1'b0, tx_irq_o)
    // completion and clearing write on the same edge: the completion must survive
    fork
      far.finish_tx();
      wr(CTRL_LOW_ADDR, 8'h02);
    join
    `check("set beats clear", 1'b1, tx_irq_o)
  endtask : s_irq
  task automatic s_rst();
    logic [7:0] v;
    wr(CTRL_LOW_ADDR, 8'h8e);
    far.finish_tx();
    @(negedge mclk_i);
    sys_rst_i = 1'b1;
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    `check("irq after reset", 1'b0, tx_irq_o)
    `check("ninth after reset", 1'b0, tx_ninth_bit_o)
    rd(CTRL_LOW_ADDR, v);
    `check("byte after reset", CTRL_LOW_RESET, v)
  endtask : s_rst
  task automatic s_clk();
    int pt;
    int bt;
    int exp [3] = '{4, 2, 0};
    for (int s = 0; s < 4; s++) begin
      wr(CTRL_LOW_ADDR, 8'(s << CLK_SEL_LO));
      repeat (16) @(negedge mclk_i);
      ticks(32, pt, bt);
      `check("port ticks", 4 << s, pt)
    end
    baud_divisor_value_i = 8'h01;
    for (int m = 0; m < 3; m++) begin
      // a whole number of bit periods fits the window whatever the phase
      mode_i = 2'(2 + m);
      repeat (40) @(negedge mclk_i);
      ticks(64, pt, bt);
      `check("bit ticks", exp[m], bt)
    end
  endtask : s_clk
  task automatic results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge mclk_i);
    num_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    s_map();
    s_ninth();
    s_rx();
    s_irq();
    s_clk();
    s_rst();
    results();
  end
endmodule : uart_parity_clock_control_test
`default_nettype wire
